// File: rtl/iosc_pkg.sv
// Package of constants and types for the internal oscillator select and status block
package iosc_pkg;

    // ************************************************************
    // Register map (byte addresses on the APB)
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_TUNING = 12'h008;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CO_FREQ_LSB = 4;
    localparam int CO_FREQ_MSB = 6;
    localparam int CT_PLL_RUN = 7;
    localparam int CT_SEC_RUN = 6;
    localparam int CT_MF_SEL = 4;
    localparam int CT_SEC_START = 3;
    localparam int CT_PRIM_DRIVE = 2;
    localparam int CT_MF_STABLE = 1;
    localparam int CT_LF_STABLE = 0;
    localparam int TU_SRC_SEL = 7;
    localparam int TU_TRIM_MSB = 5;
    localparam int TU_TRIM_LSB = 0;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [2:0] RST_FREQ_SEL = 3'h3;
    localparam logic RST_MF_SEL = 1'b0;
    localparam logic RST_SEC_START = 1'b0;
    localparam logic RST_PRIM_DRIVE = 1'b1;
    localparam logic RST_SRC_SEL = 1'b0;
    localparam logic [5:0] RST_TRIM = 6'h00;

    // ************************************************************
    // Frequency select codes and divider ratios (log2)
    // ************************************************************
    localparam logic [2:0] FREQ_16M = 3'h7;
    localparam logic [2:0] FREQ_8M = 3'h6;
    localparam logic [2:0] FREQ_4M = 3'h5;
    localparam logic [2:0] FREQ_2M = 3'h4;
    localparam logic [2:0] FREQ_1M = 3'h3;
    localparam logic [2:0] FREQ_500K = 3'h2;
    localparam logic [2:0] FREQ_250K = 3'h1;
    localparam logic [2:0] FREQ_31K = 3'h0;
    localparam int DIV_LOG2_MAX = 9;
    localparam logic [3:0] DIV_HF_31K = 4'h9;
    localparam logic [3:0] DIV_MF_31K = 4'h4;
    localparam int STABLE_TICKS = 8;

    // Source of the internal clock
    typedef enum logic [1:0] {
        SRC_HF = 2'b00,
        SRC_MF = 2'b01,
        SRC_LF = 2'b10
    } iosc_src_t;

endpackage

// File: rtl/iosc_divider.sv
// Tick divider that turns oscillator ticks into internal clock ticks
`timescale 1ns/100ps
module iosc_divider import iosc_pkg::*; #(
    parameter int CNT_W = 9
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic restart,
    input wire logic tick_in,
    input wire logic [3:0] div_log2,
    // Divided tick
    output logic tick_out
);

    // ************************************************************
    // Parameter check
    // ************************************************************
    if (CNT_W < DIV_LOG2_MAX) begin : g_bad_width
        $error("iosc_divider: counter too narrow for the largest ratio");
    end

    logic [CNT_W-1:0] cnt_q, cnt_d, limit;
    logic tick_d;

    // All ones shifted left then inverted gives ratio minus one
    assign limit = ~({CNT_W{1'b1}} << div_log2);

    // Next count and tick
    always_comb begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (restart) begin
            cnt_d = '0;
        end else if (tick_in) begin
            if (cnt_q == limit) begin
                cnt_d = '0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + CNT_W'(1);
            end
        end
    end

    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
            tick_out <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_out <= tick_d;
        end
    end

endmodule // iosc_divider

// File: rtl/iosc_stable_det.sv
// Stability detector that counts oscillator ticks after enable
`timescale 1ns/100ps
module iosc_stable_det #(
    parameter int TICKS = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Oscillator
    input wire logic enable,
    input wire logic tick,
    // Flag
    output logic stable
);

    if (TICKS < 1 || TICKS > 255) begin : g_bad_ticks
        $error("iosc_stable_det: TICKS must be 1 to 255");
    end

    localparam logic [7:0] LAST = 8'(TICKS - 1);
    logic [7:0] cnt_q, cnt_d;
    logic stable_d;

    // Stable once enough ticks were seen; a disable starts over
    always_comb begin
        cnt_d = cnt_q;
        stable_d = stable;
        if (!enable) begin
            cnt_d = 8'h00;
            stable_d = 1'b0;
        end else if (tick && !stable) begin
            if (cnt_q == LAST) begin
                stable_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 8'h01;
            end
        end
    end

    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
            stable <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            stable <= stable_d;
        end
    end

endmodule // iosc_stable_det

// File: rtl/iosc_top.sv
// Internal oscillator select, tuning and status with an APB register slave
//
// Function
// - PLL run flag follows system clock source
// - Secondary run flag follows system clock source
// - Medium select moves low rates to medium
// - Secondary start enables oscillator, others may hold
// - Secondary start cleared by a write or power-on, kept over other resets
// - Primary drive bit, resets to one
// - Read-only stability flags for medium, low
// - Low oscillator fixed rate, never trimmed
// - Low oscillator feeds clock and timers
// - Divider plus low source into one clock
// - Three-bit select picks one of eight
// - Any reset selects one megahertz
// - 500k and 250k from medium or high
// - 31k from low, medium or high
// - Six-bit trim for high and medium
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module iosc_top import iosc_pkg::*; #(
    parameter int MF_STABLE_TICKS = STABLE_TICKS,
    parameter int LF_STABLE_TICKS = STABLE_TICKS
) (
    // Clock and power-on reset
    input wire logic pclk,
    input wire logic presetn,
    // Any other reset, one-cycle pulse
    input wire logic warm_reset,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System clock source status
    input wire logic sys_clk_from_pll,
    input wire logic sys_clk_from_secondary,
    input wire logic secondary_other_request,
    // Oscillator ticks
    input wire logic hf_tick,
    input wire logic mf_tick,
    input wire logic lf_tick,
    // Oscillator controls
    output logic [5:0] hf_trim,
    output logic [5:0] mf_trim,
    output logic mf_osc_enable,
    output logic secondary_osc_enable,
    output logic primary_drive_enable,
    // Clock outputs
    output logic internal_clock_output,
    output logic [1:0] internal_clock_src,
    output logic lf_timer_tick
);

    // ************************************************************
    // Control registers
    // ************************************************************
    logic [2:0] freq_sel_q, freq_sel_d;
    logic mf_sel_q, mf_sel_d;
    logic prim_drive_q, prim_drive_d;
    logic src_sel_q, src_sel_d;
    logic [5:0] trim_q, trim_d;
    logic sec_start_q, sec_start_d;
    logic pll_run_q, sec_run_q;
    logic mf_stable, lf_stable;
    logic wr_en;

    // A write lands only on the completing edge of the access phase
    assign wr_en = psel && penable && pready && pwrite && pstrb[0];

    // Next control values; reset beats a write in the same cycle
    always_comb begin
        freq_sel_d = freq_sel_q;
        mf_sel_d = mf_sel_q;
        prim_drive_d = prim_drive_q;
        src_sel_d = src_sel_q;
        trim_d = trim_q;
        sec_start_d = sec_start_q;
        if (warm_reset) begin
            freq_sel_d = RST_FREQ_SEL;
            mf_sel_d = RST_MF_SEL;
            prim_drive_d = RST_PRIM_DRIVE;
            src_sel_d = RST_SRC_SEL;
            trim_d = RST_TRIM;
            sec_start_d = sec_start_q;
        end else if (wr_en) begin
            unique case (paddr)
                ADDR_CTRL_ONE: begin
                    freq_sel_d = pwdata[CO_FREQ_MSB:CO_FREQ_LSB];
                end
                ADDR_CTRL_TWO: begin
                    mf_sel_d = pwdata[CT_MF_SEL];
                    sec_start_d = pwdata[CT_SEC_START];
                    prim_drive_d = pwdata[CT_PRIM_DRIVE];
                end
                ADDR_TUNING: begin
                    src_sel_d = pwdata[TU_SRC_SEL];
                    trim_d = pwdata[TU_TRIM_MSB:TU_TRIM_LSB];
                end
                default: begin
                    // Unmapped write changes nothing
                end
            endcase
        end
    end

    // Control flip-flops; the power-on reset is the only one that clears everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_sel_q <= RST_FREQ_SEL;
            mf_sel_q <= RST_MF_SEL;
            prim_drive_q <= RST_PRIM_DRIVE;
            src_sel_q <= RST_SRC_SEL;
            trim_q <= RST_TRIM;
            sec_start_q <= RST_SEC_START;
        end else begin
            freq_sel_q <= freq_sel_d;
            mf_sel_q <= mf_sel_d;
            prim_drive_q <= prim_drive_d;
            src_sel_q <= src_sel_d;
            trim_q <= trim_d;
            sec_start_q <= sec_start_d;
        end
    end

    // ************************************************************
    // Run status
    // ************************************************************
    // Sampled once so software always reads a settled level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_run_q <= 1'b0;
            sec_run_q <= 1'b0;
        end else begin
            pll_run_q <= sys_clk_from_pll;
            sec_run_q <= sys_clk_from_secondary;
        end
    end

    // ************************************************************
    // Source and divider selection
    // ************************************************************
    iosc_src_t src_d, src_q;
    logic [3:0] div_d, div_q;
    logic restart_d, restart_q;
    logic src_tick;

    // Map the select code onto a source and a power-of-two ratio
    always_comb begin
        src_d = SRC_HF;
        div_d = 4'h0;
        unique case (freq_sel_q)
            FREQ_16M: div_d = 4'h0;
            FREQ_8M: div_d = 4'h1;
            FREQ_4M: div_d = 4'h2;
            FREQ_2M: div_d = 4'h3;
            FREQ_1M: div_d = 4'h4;
            FREQ_500K: begin
                src_d = mf_sel_q ? SRC_MF : SRC_HF;
                div_d = mf_sel_q ? 4'h0 : 4'h5;
            end
            FREQ_250K: begin
                src_d = mf_sel_q ? SRC_MF : SRC_HF;
                div_d = mf_sel_q ? 4'h1 : 4'h6;
            end
            FREQ_31K: begin
                if (!src_sel_q) begin
                    src_d = SRC_LF;
                    div_d = 4'h0;
                end else if (mf_sel_q) begin
                    src_d = SRC_MF;
                    div_d = DIV_MF_31K;
                end else begin
                    src_d = SRC_HF;
                    div_d = DIV_HF_31K;
                end
            end
        endcase
        // A change of path restarts the divider so no runt count survives
        restart_d = (src_d != src_q) || (div_d != div_q);
    end

    // Selection registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_q <= SRC_HF;
            div_q <= 4'h4;
            restart_q <= 1'b0;
        end else begin
            src_q <= src_d;
            div_q <= div_d;
            restart_q <= restart_d;
        end
    end

    // Tick of the selected oscillator
    always_comb begin
        unique case (src_q)
            SRC_HF: src_tick = hf_tick;
            SRC_MF: src_tick = mf_tick;
            SRC_LF: src_tick = lf_tick;
            default: src_tick = 1'b0;
        endcase
    end

    iosc_divider #(
        .CNT_W(DIV_LOG2_MAX)
    ) u_divider (
        .pclk(pclk),
        .presetn(presetn),
        .restart(restart_q),
        .tick_in(src_tick),
        .div_log2(div_q),
        .tick_out(internal_clock_output)
    );

    // ************************************************************
    // Stability detection
    // ************************************************************
    // medium stability flag
    iosc_stable_det #(
        .TICKS(MF_STABLE_TICKS)
    ) u_mf_stable (
        .pclk(pclk),
        .presetn(presetn),
        .enable(mf_osc_enable),
        .tick(mf_tick),
        .stable(mf_stable)
    );

    // low stability flag; the low oscillator never stops
    iosc_stable_det #(
        .TICKS(LF_STABLE_TICKS)
    ) u_lf_stable (
        .pclk(pclk),
        .presetn(presetn),
        .enable(1'b1),
        .tick(lf_tick),
        .stable(lf_stable)
    );

    // ************************************************************
    // Oscillator control outputs
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hf_trim <= RST_TRIM;
            mf_trim <= RST_TRIM;
            mf_osc_enable <= 1'b0;
            secondary_osc_enable <= 1'b0;
            primary_drive_enable <= RST_PRIM_DRIVE;
            internal_clock_src <= SRC_HF;
            lf_timer_tick <= 1'b0;
        end else begin
            // trim to high and medium only
            hf_trim <= trim_q;
            mf_trim <= trim_q;
            mf_osc_enable <= (src_d == SRC_MF);
            secondary_osc_enable <= sec_start_q || secondary_other_request;
            primary_drive_enable <= prim_drive_q;
            internal_clock_src <= src_q;
            lf_timer_tick <= lf_tick;
        end
    end
    // the low oscillator gets no trim port at all, so tuning cannot move it

    // ************************************************************
    // APB read and answer
    // ************************************************************
    logic [31:0] rd_d;
    logic hit;
    logic pready_d, pslverr_d;
    logic [31:0] prdata_d;

    // Read mux; unused bits, bit five of ADDR_CTRL_TWO among them, read as zero
    always_comb begin
        rd_d = 32'h0000_0000;
        hit = 1'b1;
        unique case (paddr)
            ADDR_CTRL_ONE: rd_d[CO_FREQ_MSB:CO_FREQ_LSB] = freq_sel_q;
            ADDR_CTRL_TWO: begin
                rd_d[CT_PLL_RUN] = pll_run_q;
                rd_d[CT_SEC_RUN] = sec_run_q;
                rd_d[CT_MF_SEL] = mf_sel_q;
                rd_d[CT_SEC_START] = sec_start_q;
                rd_d[CT_PRIM_DRIVE] = prim_drive_q;
                rd_d[CT_MF_STABLE] = mf_stable;
                rd_d[CT_LF_STABLE] = lf_stable;
            end
            ADDR_TUNING: begin
                rd_d[TU_SRC_SEL] = src_sel_q;
                rd_d[TU_TRIM_MSB:TU_TRIM_LSB] = trim_q;
            end
            default: hit = 1'b0;
        endcase
    end

    // No wait state: answer is prepared in the setup cycle
    always_comb begin
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = prdata;
        if (psel && !penable) begin
            pready_d = 1'b1;
            pslverr_d = !hit;
            prdata_d = pwrite ? 32'h0000_0000 : rd_d;
        end else if (psel && penable && !pready) begin
            // Back-to-back master out of step: answer next edge
            pready_d = 1'b1;
            pslverr_d = !hit;
            prdata_d = pwrite ? 32'h0000_0000 : rd_d;
        end
    end

    // Bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= pready_d;
            pslverr <= pslverr_d;
            prdata <= prdata_d;
        end
    end

    // trim direction is a software decision; the field is plain read/write

endmodule // iosc_top

// File: test/iosc_checker.sv
// Port checker for the internal oscillator select and status block
`timescale 1ns/100ps
module iosc_checker import iosc_pkg::*; (
    // Clock and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic warm_reset,
    // APB
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Side signals
    input wire logic secondary_other_request,
    input wire logic lf_tick,
    input wire logic [5:0] hf_trim,
    input wire logic primary_drive_enable,
    input wire logic secondary_osc_enable,
    input wire logic lf_timer_tick,
    input wire logic [1:0] internal_clock_src
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped;
    // Only the three register words answer without error
    assign mapped = paddr == ADDR_CTRL_ONE || paddr == ADDR_CTRL_TWO || paddr == ADDR_TUNING;
    a_pready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_pready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_upper_bytes_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read bytes not zero");
    a_slverr_decode: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    a_bit_five_zero: assert property (pready && !pwrite && paddr == ADDR_CTRL_TWO |-> !prdata[5])
        else $error("bit five reads one");
    a_secondary_held: assert property (secondary_other_request |=> secondary_osc_enable)
        else $error("secondary dropped while requested");
    // Start only from an edge that saw reset high, so the edge of release cannot fire it
    a_lf_timer_copy: assert property (presetn |=> lf_timer_tick == $past(lf_tick))
        else $error("timer tick not copy of low tick");
    a_trim_on_write: assert property ($changed(hf_trim) |->
        $past(pready && pwrite && paddr == ADDR_TUNING, 2) || $past(warm_reset, 2))
        else $error("trim changed without write");
    a_prim_warm_reset: assert property (warm_reset |-> ##2 primary_drive_enable)
        else $error("primary drive not restored");
    a_src_legal: assert property (internal_clock_src != 2'b11)
        else $error("illegal clock source code");
    // Main scenarios
    c_error: cover property (pready && pslverr);
    c_warm: cover property (warm_reset);
    c_medium: cover property (internal_clock_src == SRC_MF);
    c_shared: cover property (secondary_other_request && secondary_osc_enable);
endmodule // iosc_checker

bind iosc_top iosc_checker chk (.pclk(pclk), .presetn(presetn), .warm_reset(warm_reset), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .secondary_other_request(secondary_other_request), .lf_tick(lf_tick), .hf_trim(hf_trim),
    .primary_drive_enable(primary_drive_enable), .secondary_osc_enable(secondary_osc_enable),
    .lf_timer_tick(lf_timer_tick), .internal_clock_src(internal_clock_src));

// File: test/test_iosc_top.sv
// Self-checking bench for the internal oscillator select and status block
`timescale 1ns/100ps
module test_iosc_top import iosc_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, warm_reset = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, sys_clk_from_pll = 1'b0, sys_clk_from_secondary = 1'b0, secondary_other_request = 1'b0;
    logic hf_tick = 1'b0, mf_tick = 1'b0, lf_tick = 1'b0, mf_osc_enable, secondary_osc_enable;
    logic primary_drive_enable, internal_clock_output, lf_timer_tick;
    logic [5:0] hf_trim, mf_trim;
    logic [1:0] internal_clock_src;
    logic [2:0] tcnt = 3'h0;
    int errors = 0, samples_checked = 0, cycles = 0;

    iosc_top #(.MF_STABLE_TICKS(2), .LF_STABLE_TICKS(2)) dut (.pclk(pclk), .presetn(presetn),
        .warm_reset(warm_reset), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sys_clk_from_pll(sys_clk_from_pll), .sys_clk_from_secondary(sys_clk_from_secondary),
        .secondary_other_request(secondary_other_request), .hf_tick(hf_tick), .mf_tick(mf_tick),
        .lf_tick(lf_tick), .hf_trim(hf_trim), .mf_trim(mf_trim), .mf_osc_enable(mf_osc_enable),
        .secondary_osc_enable(secondary_osc_enable), .primary_drive_enable(primary_drive_enable),
        .internal_clock_output(internal_clock_output), .internal_clock_src(internal_clock_src),
        .lf_timer_tick(lf_timer_tick));

    // ****************************************
    // Clock, oscillator ticks and timeout
    // ****************************************
    initial begin
        forever #10 pclk = ~pclk;
    end
    // Ticks every 2, 4 and 8 cycles so every ratio shows as a distinct period
    always @(posedge pclk) begin
        tcnt <= tcnt + 3'h1;
        hf_tick <= tcnt[0] == 1'b0;
        mf_tick <= tcnt[1:0] == 2'h0;
        lf_tick <= tcnt == 3'h0;
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            print_verdict();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic print_verdict();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Holds the whole request until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [32:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No own limit: only the bench timeout ends a missing answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic err);
        logic [32:0] r;
        apb(1'b1, a, {24'h000000, d}, r);
        check({31'h0, r[32]}, {31'h0, err});
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [31:0] mask, input logic err);
        logic [32:0] r;
        apb(1'b0, a, 32'h00000000, r);
        check(r[31:0] & mask, exp);
        check({31'h0, r[32]}, {31'h0, err});
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_values();
        rd(ADDR_CTRL_ONE, 32'h30, 32'hFF, 1'b0);
        rd(ADDR_CTRL_TWO, 32'h04, 32'hFC, 1'b0);
        rd(ADDR_TUNING, 32'h00, 32'hFF, 1'b0);
        check({31'h0, primary_drive_enable}, 32'h1);
    endtask
    task automatic t_status();
        sys_clk_from_pll <= 1'b1;
        wait_cyc(3);
        wr(ADDR_CTRL_TWO, 8'hFF, 1'b0);
        rd(ADDR_CTRL_TWO, 32'h9D, 32'hFF, 1'b0);
        sys_clk_from_pll <= 1'b0;
        sys_clk_from_secondary <= 1'b1;
        wait_cyc(3);
        rd(ADDR_CTRL_TWO, 32'h5D, 32'hFF, 1'b0);
        sys_clk_from_secondary <= 1'b0;
        wr(ADDR_CTRL_TWO, 8'h04, 1'b0);
    endtask
    task automatic t_secondary();
        wr(ADDR_CTRL_TWO, 8'h0C, 1'b0);
        wait_cyc(2);
        check({31'h0, secondary_osc_enable}, 32'h1);
        secondary_other_request <= 1'b1;
        wr(ADDR_CTRL_TWO, 8'h04, 1'b0);
        wait_cyc(2);
        check({31'h0, secondary_osc_enable}, 32'h1);
        secondary_other_request <= 1'b0;
        wait_cyc(2);
        check({31'h0, secondary_osc_enable}, 32'h0);
        wr(ADDR_CTRL_TWO, 8'h08, 1'b0);
        wr(ADDR_CTRL_ONE, 8'h70, 1'b0);
        wr(ADDR_TUNING, 8'h95, 1'b0);
        wait_cyc(2);
        check({31'h0, primary_drive_enable}, 32'h0);
        warm_reset <= 1'b1;
        @(posedge pclk);
        warm_reset <= 1'b0;
        rd(ADDR_CTRL_TWO, 32'h0D, 32'hFF, 1'b0);
        rd(ADDR_CTRL_ONE, 32'h30, 32'hFF, 1'b0);
        rd(ADDR_TUNING, 32'h00, 32'hFF, 1'b0);
        // Of the resets, only a power-on reset in mid-run clears the start bit
        presetn <= 1'b0;
        wait_cyc(3);
        presetn <= 1'b1;
        rd(ADDR_CTRL_TWO, 32'h04, 32'hFC, 1'b0);
    endtask
    task automatic t_trim_and_map();
        wr(ADDR_TUNING, 8'hFF, 1'b0);
        rd(ADDR_TUNING, 32'hBF, 32'hFFFFFFFF, 1'b0);
        wait_cyc(2);
        check({20'h0, hf_trim, mf_trim}, 32'hFFF);
        pstrb <= 4'h0;
        wr(ADDR_TUNING, 8'h00, 1'b0);
        pstrb <= 4'hF;
        rd(ADDR_TUNING, 32'hBF, 32'hFF, 1'b0);
        // Software steps the trim one down, as a too fast clock would call for
        wr(ADDR_TUNING, 8'hBE, 1'b0);
        rd(ADDR_TUNING, 32'hBE, 32'hFF, 1'b0);
        wr(12'h00C, 8'h55, 1'b1);
        rd(12'h00C, 32'h00, 32'hFFFFFFFF, 1'b1);
        wr(ADDR_TUNING, 8'h00, 1'b0);
    endtask
    task automatic t_freq();
        logic [2:0] code [12] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0, 3'h2, 3'h1, 3'h0};
        logic [11:0] mfs = 12'b000000000111;
        logic [11:0] srcs = 12'b111111110001;
        int per [12] = '{2, 4, 8, 16, 32, 64, 128, 1024, 8, 4, 8, 64};
        logic [1:0] src [12] = '{SRC_HF, SRC_HF, SRC_HF, SRC_HF, SRC_HF, SRC_HF, SRC_HF, SRC_HF,
            SRC_LF, SRC_MF, SRC_MF, SRC_MF};
        int n;
        for (int i = 0; i < 12; i++) begin
            wr(ADDR_CTRL_TWO, {3'h0, mfs[11-i], 4'h4}, 1'b0);
            wr(ADDR_TUNING, {srcs[11-i], 7'h00}, 1'b0);
            wr(ADDR_CTRL_ONE, {1'b0, code[i], 4'h0}, 1'b0);
            // Skip two pulses so a stale one from the old ratio is not measured
            for (int k = 0; k < 3; k++) begin
                n = 0;
                do begin
                    @(posedge pclk);
                    n++;
                end while (internal_clock_output !== 1'b1 && n < 3000);
            end
            check(32'(n), 32'(per[i]));
            check({30'h0, internal_clock_src}, {30'h0, src[i]});
            check({31'h0, mf_osc_enable}, {31'h0, src[i] == SRC_MF});
            rd(ADDR_CTRL_TWO, 32'({mfs[11-i], 2'h1, src[i] == SRC_MF, 1'b1}), 32'h17, 1'b0);
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        wait_cyc(8);
        presetn <= 1'b1;
        t_reset_values();
        t_status();
        t_secondary();
        t_trim_and_map();
        t_freq();
        print_verdict();
    end
endmodule // test_iosc_top
